//--- rtl/odm_pkg.sv
// Shared constants and types for the display-memory mode control block
package odm_pkg;
   localparam logic [7:0] ODM_MODE_WR_ADDR = 8'h04;
   localparam logic [7:0] ODM_MODE_RD_ADDR = 8'h84;
   localparam logic [7:0] ODM_DATA_WR_ADDR = 8'h07;
   localparam logic [7:0] ODM_MODE_RESET = 8'h00;
   localparam logic [7:0] ODM_ESCAPE = 8'hff;
   localparam logic [4:0] ODM_ATTR_PAD = 5'h00;
   localparam logic [7:0] ODM_ZERO_BYTE = 8'h00;
   // Mode register field positions
   localparam int ODM_B_MODE8 = 6;
   localparam int ODM_B_LBC = 5;
   localparam int ODM_B_BLK = 4;
   localparam int ODM_B_INV = 3;
   localparam int ODM_B_CLR = 2;
   localparam int ODM_B_VSC = 1;
   localparam int ODM_B_AUTO = 0;
   localparam int ODM_ADDR_W = 9;
   // Clear duration
   localparam int ODM_CLEAR_US = 20;
   localparam int ODM_CLK_MHZ = 100;
   localparam int ODM_CLEAR_CYC = ODM_CLEAR_US * ODM_CLK_MHZ;
   localparam int ODM_CNT_W = $clog2(ODM_CLEAR_CYC + 1);
   localparam int ODM_MEM_WORDS = 512;

   typedef enum logic [1:0]
   {
      ODM_PIX_VIDEO = 2'b00,
      ODM_PIX_BG = 2'b01,
      ODM_PIX_BLACK = 2'b10,
      ODM_PIX_WHITE = 2'b11
   } odm_pix_type;

   typedef enum logic [1:0]
   {
      ODM_CLR_IDLE = 2'b00,
      ODM_CLR_WAIT = 2'b01,
      ODM_CLR_RUN = 2'b10
   } odm_clr_type;
endpackage

//--- rtl/odm_clear_engine.sv
// Display-memory clear sequencer: optional vsync wait, then timed zero fill
`timescale 1ns/1ps
module odm_clear_engine
   import odm_pkg::*;
#(
   parameter int CLEAR_CYC = ODM_CLEAR_CYC,
   parameter int MEM_WORDS = ODM_MEM_WORDS
)
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_start,
   input wire logic i_wait_vsync,
   input wire logic i_vsync,
   output logic o_busy,
   output logic o_wr,
   output logic [ODM_ADDR_W-1:0] o_addr
);
   // Counter sized from the parameters so a longer clear cannot wrap it
   localparam int CYC_W = $clog2(CLEAR_CYC + 1);
   localparam int WRD_W = $clog2(MEM_WORDS + 1);
   localparam int CNT_W = (CYC_W > WRD_W) ? CYC_W : WRD_W;
   localparam logic [CNT_W-1:0] LAST = CNT_W'(CLEAR_CYC - 1);
   localparam logic [CNT_W-1:0] WORDS = CNT_W'(MEM_WORDS);
   localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

   odm_clr_type state_q, state_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;

   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      unique case (state_q)
         ODM_CLR_IDLE:
         begin
            cnt_d = '0;
            if (i_start)
               state_d = i_wait_vsync ? ODM_CLR_WAIT : ODM_CLR_RUN;
         end
         ODM_CLR_WAIT:
         begin
            if (i_vsync)
               state_d = ODM_CLR_RUN;
         end
         ODM_CLR_RUN:
         begin
            cnt_d = cnt_q + ONE;
            if (cnt_q == LAST)
            begin
               state_d = ODM_CLR_IDLE;
               cnt_d = '0;
            end
         end
         default:
            state_d = ODM_CLR_IDLE;
      endcase
   end

   // Reset lands in the run state: clear at power-up and after reset
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         state_q <= ODM_CLR_RUN;
         cnt_q <= '0;
      end
      else if (i_ce)
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   assign o_busy = (state_q != ODM_CLR_IDLE);
   assign o_wr = (state_q == ODM_CLR_RUN) && (cnt_q < WORDS);
   assign o_addr = ODM_ADDR_W'(cnt_q);

   AST_CLEAR_LEN: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && state_q == ODM_CLR_RUN && cnt_q == LAST)
      |=> state_q == ODM_CLR_IDLE)
      else $error("clear did not end at its programmed length");
endmodule

//--- rtl/odm_mode_ctrl.sv
// Display-memory mode register, memory write steering and pixel select
// Functional notes
// - 16-bit mode copies default attributes on write
// - External sync, background bit 0: show video
// - Background bit 1: show background brightness level
// - Internal sync forces background bit to one
// - Bit 4 default blink, uses blink timing
// - Blink off phase: video external, background internal
// - Bit 3 default invert swaps black and white
// - Bit 2 clears memory, self-clears after 20us
// - Clear runs at reset and software reset
// - Bit 1 defers clear until next vsync
// - Auto-increment start takes external address registers
// - Auto mode advances address, host sends data
// - 8-bit mode writes: byte select picks character/attribute
// - Escape byte ends auto mode, not stored
// - Setting clear bit resets auto-increment bit
// - Bit 6 selects 16-bit or 8-bit mode
`timescale 1ns/1ps
module odm_mode_ctrl
   import odm_pkg::*;
#(
   parameter int CLEAR_CYC = ODM_CLEAR_CYC,
   parameter int MEM_WORDS = ODM_MEM_WORDS
)
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   input wire logic i_sw_reset_done,
   input wire logic i_vsync,
   input wire logic [ODM_ADDR_W-1:0] i_addr_base,
   input wire logic i_byte_sel,
   output logic o_mem_char_we,
   output logic o_mem_attr_we,
   output logic [ODM_ADDR_W-1:0] o_mem_addr,
   output logic [7:0] o_mem_char,
   output logic [7:0] o_mem_attr,
   output logic o_clear_busy,
   input wire logic i_ext_sync,
   input wire logic i_bg_mode,
   input wire logic [2:0] i_bg_level,
   input wire logic i_pix_glyph,
   input wire logic i_pix_white,
   input wire logic i_attr_lbc,
   input wire logic i_attr_blk,
   input wire logic i_attr_inv,
   input wire logic i_blink_on,
   output odm_pix_type o_pix_src,
   output logic [2:0] o_pix_level
);
   localparam logic [ODM_ADDR_W-1:0] ADDR_ONE = ODM_ADDR_W'(1);

   ////////////////////////////////////////////////////////////////////////////
   // Register writes and auto-increment state
   logic mode8_q, mode8_d;
   logic [2:0] dflt_q, dflt_d;
   logic vsc_q, vsc_d;
   logic auto_q, auto_d;
   logic [ODM_ADDR_W-1:0] acnt_q, acnt_d;
   logic [7:0] rdata_q, rdata_d;
   logic mode_wr, data_wr, clr_req, esc, store;
   logic clr_busy, clr_wr;
   logic [ODM_ADDR_W-1:0] clr_addr;

   // Writes during a clear are dropped; the host should not issue them
   assign mode_wr = i_reg_wr && i_reg_addr == ODM_MODE_WR_ADDR
      && !clr_busy;
   assign data_wr = i_reg_wr && i_reg_addr == ODM_DATA_WR_ADDR && !clr_busy;
   assign clr_req = (mode_wr && i_reg_wdata[ODM_B_CLR])
      || i_sw_reset_done;
   assign esc = data_wr && auto_q && i_reg_wdata == ODM_ESCAPE;
   assign store = data_wr && !esc;

   odm_clear_engine #(
      .CLEAR_CYC(CLEAR_CYC),
      .MEM_WORDS(MEM_WORDS)
   ) u_clear (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_start(clr_req),
      .i_wait_vsync(mode_wr && i_reg_wdata[ODM_B_VSC]),
      .i_vsync(i_vsync),
      .o_busy(clr_busy),
      .o_wr(clr_wr),
      .o_addr(clr_addr)
   );

   assign o_clear_busy = clr_busy;

   always_comb
   begin
      mode8_d = mode8_q;
      dflt_d = dflt_q;
      vsc_d = vsc_q;
      auto_d = auto_q;
      acnt_d = acnt_q;
      rdata_d = rdata_q;
      if (mode_wr)
      begin
         mode8_d = i_reg_wdata[ODM_B_MODE8];
         dflt_d = i_reg_wdata[ODM_B_LBC:ODM_B_INV];
         vsc_d = i_reg_wdata[ODM_B_VSC];
         auto_d = i_reg_wdata[ODM_B_AUTO];
         if (i_reg_wdata[ODM_B_AUTO] && !auto_q)
            acnt_d = i_addr_base;
      end
      if (esc)
         auto_d = 1'b0;
      if (clr_req)
         auto_d = 1'b0;
      if (store && auto_q)
         acnt_d = acnt_q + ADDR_ONE;
      if (i_reg_rd && i_reg_addr == ODM_MODE_RD_ADDR)
      begin
         rdata_d = ODM_MODE_RESET;
         rdata_d[ODM_B_MODE8] = mode8_q;
         rdata_d[ODM_B_LBC:ODM_B_INV] = dflt_q;
         rdata_d[ODM_B_CLR] = clr_busy;
         rdata_d[ODM_B_VSC] = vsc_q;
         rdata_d[ODM_B_AUTO] = auto_q;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         mode8_q <= 1'b0;
         dflt_q <= 3'h0;
         vsc_q <= 1'b0;
         auto_q <= 1'b0;
         acnt_q <= '0;
         rdata_q <= ODM_MODE_RESET;
      end
      else if (i_ce)
      begin
         mode8_q <= mode8_d;
         dflt_q <= dflt_d;
         vsc_q <= vsc_d;
         auto_q <= auto_d;
         acnt_q <= acnt_d;
         rdata_q <= rdata_d;
      end
   end

   assign o_reg_rdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // Display-memory write port
   logic cwe_q, cwe_d, awe_q, awe_d;
   logic [ODM_ADDR_W-1:0] maddr_q, maddr_d;
   logic [7:0] mchar_q, mchar_d, mattr_q, mattr_d;

   always_comb
   begin
      cwe_d = 1'b0;
      awe_d = 1'b0;
      maddr_d = maddr_q;
      mchar_d = mchar_q;
      mattr_d = mattr_q;
      if (clr_wr)
      begin
         cwe_d = 1'b1;
         awe_d = 1'b1;
         maddr_d = clr_addr;
         mchar_d = ODM_ZERO_BYTE;
         mattr_d = ODM_ZERO_BYTE;
      end
      else if (store)
      begin
         maddr_d = auto_q ? acnt_q : i_addr_base;
         mchar_d = i_reg_wdata;
         if (!mode8_q)
         begin
            cwe_d = 1'b1;
            awe_d = 1'b1;
            mattr_d = {dflt_q, ODM_ATTR_PAD};
         end
         else
         begin
            cwe_d = !i_byte_sel;
            awe_d = i_byte_sel;
            mattr_d = i_reg_wdata;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         cwe_q <= 1'b0;
         awe_q <= 1'b0;
         maddr_q <= '0;
         mchar_q <= ODM_ZERO_BYTE;
         mattr_q <= ODM_ZERO_BYTE;
      end
      else if (i_ce)
      begin
         cwe_q <= cwe_d;
         awe_q <= awe_d;
         maddr_q <= maddr_d;
         mchar_q <= mchar_d;
         mattr_q <= mattr_d;
      end
   end

   assign o_mem_char_we = cwe_q;
   assign o_mem_attr_we = awe_q;
   assign o_mem_addr = maddr_q;
   assign o_mem_char = mchar_q;
   assign o_mem_attr = mattr_q;

   ////////////////////////////////////////////////////////////////////////////
   // Pixel source select
   odm_pix_type pix_q, pix_d;
   logic [2:0] lvl_q, lvl_d;
   logic lbc_eff, blank;

   assign lbc_eff = !i_ext_sync || i_attr_lbc || i_bg_mode;
   assign blank = i_attr_blk && !i_blink_on;

   always_comb
   begin
      lvl_d = i_bg_level;
      if (blank)
         pix_d = i_ext_sync ? ODM_PIX_VIDEO : ODM_PIX_BG;
      else if (!i_pix_glyph)
         pix_d = lbc_eff ? ODM_PIX_BG : ODM_PIX_VIDEO;
      else if (i_pix_white ^ i_attr_inv)
         pix_d = ODM_PIX_WHITE;
      else
         pix_d = ODM_PIX_BLACK;
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         pix_q <= ODM_PIX_VIDEO;
         lvl_q <= 3'h0;
      end
      else if (i_ce)
      begin
         pix_q <= pix_d;
         lvl_q <= lvl_d;
      end
   end

   assign o_pix_src = pix_q;
   assign o_pix_level = lvl_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_auto_char_wr;
      i_ce && data_wr && auto_q && i_reg_wdata != ODM_ESCAPE && !clr_wr;
   endsequence

   AST_16B_ATTR: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && store && !clr_wr && !mode8_q)
      |=> o_mem_attr_we && o_mem_attr == {$past(dflt_q), ODM_ATTR_PAD})
      else $error("16-bit write did not copy default attributes");

   AST_EXT_VIDEO: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && i_ext_sync && !i_bg_mode && !i_attr_lbc && !i_pix_glyph
       && !blank) |=> o_pix_src == ODM_PIX_VIDEO)
      else $error("external sync background did not show video");

   AST_INT_BG: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && !i_ext_sync && !i_pix_glyph) |=> o_pix_src == ODM_PIX_BG)
      else $error("internal sync background not at brightness level");

   AST_BLINK_OFF: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && i_attr_blk && !i_blink_on)
      |=> o_pix_src == ($past(i_ext_sync) ? ODM_PIX_VIDEO : ODM_PIX_BG))
      else $error("blink off phase shows wrong source");

   AST_INVERT: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && i_pix_glyph && !blank && i_attr_inv && i_pix_white)
      |=> o_pix_src == ODM_PIX_BLACK)
      else $error("inverted white pixel not black");

   AST_CLR_BUSY: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && mode_wr && i_reg_wdata[ODM_B_CLR]) |=> clr_busy)
      else $error("clear request did not start");

   AST_VSYNC_WAIT: assert property (@(posedge i_clk)
      disable iff (i_rst)
      (i_ce && mode_wr && i_reg_wdata[ODM_B_CLR] && i_reg_wdata[ODM_B_VSC])
      ##1 (!i_vsync && i_ce) |=> clr_busy && !clr_wr)
      else $error("deferred clear wrote before vsync");

   AST_AUTO_LOAD: assert property (@(posedge i_clk)
      disable iff (i_rst)
      (i_ce && mode_wr && !clr_req && i_reg_wdata[ODM_B_AUTO] && !auto_q)
      |=> auto_q && acnt_q == $past(i_addr_base))
      else $error("auto-increment did not load start address");

   AST_AUTO_STEP: assert property (@(posedge i_clk)
      disable iff (i_rst)
      s_auto_char_wr |=> o_mem_addr == $past(acnt_q)
      && acnt_q == $past(acnt_q) + ADDR_ONE)
      else $error("auto-increment address did not advance");

   AST_ESCAPE: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && esc && !clr_wr) |=> !auto_q && !o_mem_char_we && !o_mem_attr_we)
      else $error("escape byte stored or auto mode kept");

   AST_CLR_AUTO: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && clr_req) |=> !auto_q)
      else $error("clear did not reset auto-increment");
endmodule

//--- verif/odm_host.sv
// Host-side register access model driving the mode control block
`timescale 1ns/1ps
module odm_host
   import odm_pkg::*;
(
   input wire logic i_clk,
   output logic o_wr,
   output logic o_rd,
   output logic [7:0] o_addr,
   output logic [7:0] o_wdata
);
   initial
   begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 8'h00;
      o_wdata = 8'h00;
   end

   // One-cycle strobe; released address and data are scrambled
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      o_addr = a;
      o_wdata = d;
      o_wr = 1'b1;
      @(negedge i_clk);
      o_wr = 1'b0;
      o_addr = ~a;
      o_wdata = ~d;
   endtask

   task automatic rd(input logic [7:0] a);
      @(negedge i_clk);
      o_addr = a;
      o_rd = 1'b1;
      @(negedge i_clk);
      o_rd = 1'b0;
      o_addr = ~a;
   endtask

   // Auto mode: only the data byte is sent
   task automatic put(input logic [7:0] d);
      wr(ODM_DATA_WR_ADDR, d);
   endtask

   task automatic esc();
      put(ODM_ESCAPE);
   endtask
endmodule

//--- verif/osd_display_memory_mode_ctrl_bench.sv
// Self-checking bench for the display-memory mode control block
`timescale 1ns/1ps
module osd_display_memory_mode_ctrl_bench
   import odm_pkg::*;
;
   localparam int CYC = 40;
   localparam int WORDS = 16;
   logic i_clk, i_rst, i_vsync, i_sw_reset_done, i_byte_sel;
   logic ce;
   logic reg_wr, reg_rd;
   logic [7:0] reg_addr, reg_wdata, o_reg_rdata, o_mem_char, o_mem_attr;
   logic [8:0] i_addr_base, o_mem_addr;
   logic o_mem_char_we, o_mem_attr_we, o_clear_busy;
   logic i_ext_sync, i_bg_mode, i_pix_glyph, i_pix_white;
   logic i_attr_lbc, i_attr_blk, i_attr_inv, i_blink_on;
   logic [2:0] i_bg_level, o_pix_level;
   odm_pix_type o_pix_src, pexp;
   logic [26:0] notes[$];
   logic [26:0] n;
   int n_fail, compares, n_wr;
   integer seed;
   logic [7:0] d;

   odm_host odm_host_i (.i_clk(i_clk), .o_wr(reg_wr), .o_rd(reg_rd),
      .o_addr(reg_addr), .o_wdata(reg_wdata));
   odm_mode_ctrl #(.CLEAR_CYC(CYC), .MEM_WORDS(WORDS)) odm_mode_ctrl_i (
      .i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_reg_wr(reg_wr),
      .i_reg_rd(reg_rd), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
      .o_reg_rdata(o_reg_rdata), .i_sw_reset_done(i_sw_reset_done),
      .i_vsync(i_vsync), .i_addr_base(i_addr_base),
      .i_byte_sel(i_byte_sel), .o_mem_char_we(o_mem_char_we),
      .o_mem_attr_we(o_mem_attr_we), .o_mem_addr(o_mem_addr),
      .o_mem_char(o_mem_char), .o_mem_attr(o_mem_attr),
      .o_clear_busy(o_clear_busy), .i_ext_sync(i_ext_sync),
      .i_bg_mode(i_bg_mode), .i_bg_level(i_bg_level),
      .i_pix_glyph(i_pix_glyph), .i_pix_white(i_pix_white),
      .i_attr_lbc(i_attr_lbc), .i_attr_blk(i_attr_blk),
      .i_attr_inv(i_attr_inv), .i_blink_on(i_blink_on),
      .o_pix_src(o_pix_src), .o_pix_level(o_pix_level));

   initial
   begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   task automatic check(input string nm, input logic [31:0] s, e);
      compares++;
      if (s !== e)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic report_and_stop();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic note_clear();
      for (int a = 0; a < WORDS; a++)
         notes.push_back({2'b11, 9'(a), 16'h0000});
   endtask

   task automatic wait_idle();
      int k;
      k = 0;
      repeat (2) @(negedge i_clk);
      while (o_clear_busy !== 1'b0 && k < 400)
      begin
         @(negedge i_clk);
         k++;
      end
      check("clear_busy", o_clear_busy, 1'b0);
   endtask

   task automatic rd_check(input logic [7:0] e);
      odm_host_i.rd(ODM_MODE_RD_ADDR);
      check("mode_rdata", o_reg_rdata, e);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Memory write watcher: every pulse consumes the oldest note
   always @(negedge i_clk)
   begin
      if ((o_mem_char_we | o_mem_attr_we) === 1'b1)
      begin
         n_wr++;
         if (notes.size() == 0)
            check("unexpected_write", 1'b1, 1'b0);
         else
         begin
            n = notes.pop_front();
            check("we", {o_mem_char_we, o_mem_attr_we}, n[26:25]);
            check("addr", o_mem_addr, n[24:16]);
            if (n[26])
               check("char", o_mem_char, n[15:8]);
            if (n[25])
               check("attr", o_mem_attr, n[7:0]);
         end
      end
   end

   initial
   begin
      #200000;
      check("timeout", 1'b1, 1'b0);
      report_and_stop();
   end

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      seed = 32'hab1a;
      n_fail = 0;
      compares = 0;
      n_wr = 0;
      i_rst = 1'b1;
      ce = 1'b1;
      {i_vsync, i_sw_reset_done, i_byte_sel, i_addr_base} = '0;
      {i_ext_sync, i_bg_mode, i_bg_level, i_pix_glyph, i_pix_white} = '0;
      {i_attr_lbc, i_attr_blk, i_attr_inv, i_blink_on} = '0;
      note_clear();
      repeat (5) @(negedge i_clk);
      i_rst = 1'b0;
      wait_idle();
      rd_check(8'h00);
      // 16-bit mode with defaults; bit 7 reads back zero
      odm_host_i.wr(ODM_MODE_WR_ADDR, 8'hb8);
      rd_check(8'h38);
      d = 8'($random(seed)) & 8'h7f;
      i_addr_base = 9'($random(seed));
      notes.push_back({2'b11, i_addr_base, d, 8'he0});
      odm_host_i.put(d);
      // 8-bit mode, byte select steers the byte
      odm_host_i.wr(ODM_MODE_WR_ADDR, 8'h40);
      rd_check(8'h40);
      for (int b = 0; b < 2; b++)
      begin
         i_byte_sel = b[0];
         notes.push_back({~b[0], b[0], i_addr_base, 8'h5a, 8'h5a});
         odm_host_i.put(8'h5a);
      end
      // Auto mode starts at base and wraps at the top address
      i_addr_base = 9'h1ff;
      odm_host_i.wr(ODM_MODE_WR_ADDR, 8'h01);
      i_addr_base = 9'h0a0;
      for (int k = 0; k < 3; k++)
      begin
         notes.push_back({2'b11, 9'(9'h1ff + k), 8'(8'h10 + k), 8'h00});
         odm_host_i.put(8'(8'h10 + k));
      end
      odm_host_i.esc();
      rd_check(8'h00);
      notes.push_back({2'b11, i_addr_base, 8'hff, 8'h00});
      odm_host_i.put(8'hff);
      // Clear with auto requested: auto dropped, writes refused meanwhile
      odm_host_i.wr(ODM_MODE_WR_ADDR, 8'h01);
      note_clear();
      odm_host_i.wr(ODM_MODE_WR_ADDR, 8'h05);
      @(negedge i_clk);
      rd_check(8'h04);
      odm_host_i.put(8'h33);
      wait_idle();
      rd_check(8'h00);
      // Clear deferred to vertical sync
      odm_host_i.wr(ODM_MODE_WR_ADDR, 8'h06);
      d = n_wr[7:0];
      repeat (20) @(negedge i_clk);
      check("vsync_wait", {o_clear_busy, n_wr[7:0]}, {1'b1, d});
      note_clear();
      i_vsync = 1'b1;
      @(negedge i_clk);
      i_vsync = 1'b0;
      wait_idle();
      rd_check(8'h02);
      // Clear after a software reset transfer
      note_clear();
      i_sw_reset_done = 1'b1;
      @(negedge i_clk);
      i_sw_reset_done = 1'b0;
      wait_idle();
      // Pixel source selection with random inputs
      for (int k = 0; k < 96; k++)
      begin
         {i_ext_sync, i_bg_mode, i_pix_glyph, i_pix_white} = 4'($random(seed));
         {i_attr_lbc, i_attr_blk, i_attr_inv, i_blink_on} = 4'($random(seed));
         i_bg_level = 3'($random(seed));
         if (i_attr_blk & ~i_blink_on)
            pexp = i_ext_sync ? ODM_PIX_VIDEO : ODM_PIX_BG;
         else if (!i_pix_glyph)
            pexp = (!i_ext_sync | i_attr_lbc | i_bg_mode) ? ODM_PIX_BG
               : ODM_PIX_VIDEO;
         else
            pexp = (i_pix_white ^ i_attr_inv) ? ODM_PIX_WHITE
               : ODM_PIX_BLACK;
         d = {5'h00, i_bg_level};
         @(negedge i_clk);
         check("pix_src", o_pix_src, pexp);
         check("pix_level", o_pix_level, d[2:0]);
      end
      // Clock enable low freezes the registered pixel outputs
      ce = 1'b0;
      i_bg_level = ~i_bg_level;
      i_attr_blk = ~i_attr_blk;
      repeat (2) @(negedge i_clk);
      check("pix_hold", o_pix_src, pexp);
      check("level_hold", o_pix_level, d[2:0]);
      ce = 1'b1;
      check("notes_left", notes.size(), 0);
      report_and_stop();
   end
endmodule
